/* File: hw/rvc_vector_convert_regs.sv */
`default_nettype none
module rvc_vector_convert_regs #(
    parameter bit TAMPER_PRESENT = 1'b0
) (
    // clock and resets
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic RTC_SUPPLY_RST_N_I,
    // axi4-lite write address
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    // axi4-lite write data
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // axi4-lite read address
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    // axi4-lite read data
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // clock events and prescaler tick
    input wire rvc_pkg::rvc_evt_s EVENTS_I,
    input wire logic PS0_TICK_I,
    // deep_sleep_state wake-up
    output logic WAKE_O
);
    import rvc_pkg::*;

    // ========================================
    // helper functions
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_PS0) || (a == OFS_PS1) || (a == OFS_IV) || (a == OFS_B2D) ||
                 (a == OFS_D2B) || (a == OFS_SEC) || (a == OFS_FLAG) || (a == OFS_EN);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // double dabble on the 12-bit input
    function automatic logic [15:0] bin_to_bcd(input logic [11:0] b);
        logic [27:0] s;
        s = {16'h0000, b};
        for (int i = 0; i < 12; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (s[12 + d*4 +: 4] > 4'h4) begin
                    s[12 + d*4 +: 4] = s[12 + d*4 +: 4] + 4'h3;
                end
            end
            s = {s[26:0], 1'b0};
        end
        bin_to_bcd = s[27:12];
    endfunction

    // values above 4095 wrap in the 12-bit result
    function automatic logic [15:0] bcd_to_bin(input logic [15:0] d);
        logic [13:0] v;
        v = 14'(d[15:12]) * 14'd1000 + 14'(d[11:8]) * 14'd100 + 14'(d[7:4]) * 14'd10 + 14'(d[3:0]);
        bcd_to_bin = {4'h0, v[11:0]};
    endfunction

    // ========================================
    // state
    logic aw_ready_reg, w_ready_reg, b_valid_reg, ar_ready_reg, r_valid_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] b_resp_reg, r_resp_reg;
    logic [31:0] r_data_reg;
    logic [7:0] ps0_reg, ps1_reg, sec_reg;
    logic [15:0] b2d_reg, d2b_reg;
    logic [NUM_SRC-1:0] flag_reg, en_reg;
    logic wake_reg;

    // ========================================
    // write channel decode
    wire aw_hs = S_AXI_AWVALID_I && aw_ready_reg;
    wire w_hs = S_AXI_WVALID_I && w_ready_reg;
    wire aw_have = aw_hs || !aw_ready_reg;
    wire w_have = w_hs || !w_ready_reg;
    wire do_write = aw_have && w_have && !b_valid_reg;
    wire [7:0] wr_addr = aw_hs ? S_AXI_AWADDR_I : aw_addr_reg;
    wire [31:0] wr_data = w_hs ? S_AXI_WDATA_I : w_data_reg;
    wire [3:0] wr_strb = w_hs ? S_AXI_WSTRB_I : w_strb_reg;
    wire wr_ps0 = do_write && (wr_addr == OFS_PS0);
    wire wr_ps1 = do_write && (wr_addr == OFS_PS1);
    wire wr_b2d = do_write && (wr_addr == OFS_B2D);
    wire wr_d2b = do_write && (wr_addr == OFS_D2B);
    wire wr_sec = do_write && (wr_addr == OFS_SEC);
    wire wr_flag = do_write && (wr_addr == OFS_FLAG);
    wire wr_en = do_write && (wr_addr == OFS_EN);
    wire [31:0] wr_ps0_val = merge({24'h0, ps0_reg}, wr_data, wr_strb);
    wire [31:0] wr_ps1_val = merge({24'h0, ps1_reg}, wr_data, wr_strb);
    wire [31:0] wr_b2d_val = merge({16'h0, b2d_reg}, wr_data, wr_strb);
    wire [31:0] wr_d2b_val = merge({16'h0, d2b_reg}, wr_data, wr_strb);
    wire [31:0] wr_sec_val = merge({24'h0, sec_reg}, wr_data, wr_strb);
    wire [31:0] wr_en_val = merge({25'h0, en_reg}, wr_data, wr_strb);

    // ========================================
    // interrupt vector
    wire [NUM_SRC-1:0] present = TAMPER_PRESENT ? {NUM_SRC{1'b1}} : ~(7'(1) << SRC_TAMPER);
    wire [NUM_SRC-1:0] pending = flag_reg & en_reg & present;
    logic [15:0] iv_code;
    logic [NUM_SRC-1:0] iv_onehot;
    always_comb begin
        logic [15:0] code;
        code = IV_NONE;
        iv_code = IV_NONE;
        iv_onehot = '0;
        // lowest index wins, code rises by one step per present source
        for (int i = 0; i < NUM_SRC; i++) begin
            if (present[i]) begin
                code = code + IV_STEP;
                if (pending[i] && (iv_onehot == '0)) begin
                    iv_code = code;
                    iv_onehot[i] = 1'b1;
                end
            end
        end
    end

    // ========================================
    // read decode
    wire ar_hs = S_AXI_ARVALID_I && ar_ready_reg;
    wire rd_iv = ar_hs && (S_AXI_ARADDR_I == OFS_IV);
    wire [31:0] rd_mux =
        (S_AXI_ARADDR_I == OFS_PS0) ? {24'h0, ps0_reg} :
        (S_AXI_ARADDR_I == OFS_PS1) ? {24'h0, ps1_reg} :
        (S_AXI_ARADDR_I == OFS_IV) ? {16'h0, iv_code} :
        (S_AXI_ARADDR_I == OFS_B2D) ? {16'h0, bin_to_bcd(b2d_reg[11:0])} :
        (S_AXI_ARADDR_I == OFS_D2B) ? {16'h0, bcd_to_bin(d2b_reg)} :
        (S_AXI_ARADDR_I == OFS_SEC) ? {24'h0, sec_reg} :
        (S_AXI_ARADDR_I == OFS_FLAG) ? {25'h0, flag_reg & present} :
        (S_AXI_ARADDR_I == OFS_EN) ? {25'h0, en_reg} : 32'h0;

    // ========================================
    // flag update: write-one-to-clear, vector read clears one, set wins
    wire [NUM_SRC-1:0] evt = EVENTS_I & present;
    wire [NUM_SRC-1:0] clr_sw = wr_flag ? (wr_data[NUM_SRC-1:0] & {NUM_SRC{wr_strb[0]}}) : '0;
    wire [NUM_SRC-1:0] clr_iv = rd_iv ? iv_onehot : '0;
    wire [NUM_SRC-1:0] flag_next = (flag_reg & ~clr_sw & ~clr_iv) | evt;

    // prescale counting, software load takes precedence
    wire ps0_wrap = PS0_TICK_I && (ps0_reg == PS_FULL);
    wire [7:0] ps0_next = wr_ps0 ? wr_ps0_val[7:0] : (PS0_TICK_I ? ps0_reg + 8'h01 : ps0_reg);
    wire [7:0] ps1_next = wr_ps1 ? wr_ps1_val[7:0] : (ps0_wrap ? ps1_reg + 8'h01 : ps1_reg);

    // ========================================
    // axi write side
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            aw_ready_reg <= 1'b1;
            w_ready_reg <= 1'b1;
            b_valid_reg <= 1'b0;
            b_resp_reg <= RESP_OKAY;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_addr_reg <= S_AXI_AWADDR_I;
            end
            if (w_hs) begin
                w_data_reg <= S_AXI_WDATA_I;
                w_strb_reg <= S_AXI_WSTRB_I;
            end
            if (do_write) begin
                aw_ready_reg <= 1'b0;
                w_ready_reg <= 1'b0;
                b_valid_reg <= 1'b1;
                b_resp_reg <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_ready_reg <= 1'b0;
                end
                if (w_hs) begin
                    w_ready_reg <= 1'b0;
                end
                if (b_valid_reg && S_AXI_BREADY_I) begin
                    b_valid_reg <= 1'b0;
                    aw_ready_reg <= 1'b1;
                    w_ready_reg <= 1'b1;
                end
            end
        end
    end

    // ========================================
    // axi read side
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ar_ready_reg <= 1'b1;
            r_valid_reg <= 1'b0;
            r_data_reg <= 32'h0;
            r_resp_reg <= RESP_OKAY;
        end else if (ar_hs) begin
            ar_ready_reg <= 1'b0;
            r_valid_reg <= 1'b1;
            r_data_reg <= rd_mux;
            r_resp_reg <= mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
        end else if (r_valid_reg && S_AXI_RREADY_I) begin
            r_valid_reg <= 1'b0;
            ar_ready_reg <= 1'b1;
        end
    end

    // ========================================
    // core registers on power-on reset
    // prescale counts have no defined reset; cleared here for clean simulation
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ps0_reg <= PS_RST;
            ps1_reg <= PS_RST;
            b2d_reg <= CONV_RST;
            d2b_reg <= CONV_RST;
            flag_reg <= '0;
            en_reg <= '0;
            wake_reg <= 1'b0;
        end else begin
            ps0_reg <= ps0_next;
            ps1_reg <= ps1_next;
            flag_reg <= flag_next;
            wake_reg <= flag_next[SRC_PS1] && en_reg[SRC_PS1];
            if (wr_b2d) begin
                b2d_reg <= {4'h0, wr_b2d_val[11:0]};
            end
            if (wr_d2b) begin
                d2b_reg <= wr_d2b_val[15:0];
            end
            if (wr_en) begin
                en_reg <= wr_en_val[NUM_SRC-1:0];
            end
        end
    end

    // ========================================
    // backup seconds, only the supply-domain reset clears it
    always_ff @(posedge SYS_CLK_I or negedge RTC_SUPPLY_RST_N_I) begin
        if (!RTC_SUPPLY_RST_N_I) begin
            sec_reg <= SEC_RST;
        end else if (wr_sec) begin
            sec_reg <= wr_sec_val[7:0] & SEC_MASK;
        end
    end

    // ========================================
    // outputs
    assign S_AXI_AWREADY_O = aw_ready_reg;
    assign S_AXI_WREADY_O = w_ready_reg;
    assign S_AXI_BVALID_O = b_valid_reg;
    assign S_AXI_BRESP_O = b_resp_reg;
    assign S_AXI_ARREADY_O = ar_ready_reg;
    assign S_AXI_RVALID_O = r_valid_reg;
    assign S_AXI_RDATA_O = r_data_reg;
    assign S_AXI_RRESP_O = r_resp_reg;
    assign WAKE_O = wake_reg;

endmodule // rvc_vector_convert_regs
`default_nettype wire

/* File: hw/rvc_pkg.sv */
`default_nettype none
package rvc_pkg;
    // ========================================
    // register map
    localparam logic [7:0] OFS_PS0 = 8'h00;
    localparam logic [7:0] OFS_PS1 = 8'h04;
    localparam logic [7:0] OFS_IV = 8'h08;
    localparam logic [7:0] OFS_B2D = 8'h0c;
    localparam logic [7:0] OFS_D2B = 8'h10;
    localparam logic [7:0] OFS_SEC = 8'h14;
    localparam logic [7:0] OFS_FLAG = 8'h18;
    localparam logic [7:0] OFS_EN = 8'h1c;
    // ========================================
    // fields and reset values
    localparam int NUM_SRC = 7;
    localparam logic [7:0] PS_RST = 8'h00;
    localparam logic [15:0] IV_NONE = 16'h0000;
    localparam logic [15:0] CONV_RST = 16'h0000;
    localparam logic [7:0] SEC_RST = 8'h00;
    localparam logic [7:0] SEC_MASK = 8'h3f;
    localparam logic [7:0] PS_FULL = 8'hff;
    localparam logic [15:0] IV_STEP = 16'h0002;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // source index, highest priority first
    localparam int SRC_OSC = 0;
    localparam int SRC_TAMPER = 1;
    localparam int SRC_READY = 2;
    localparam int SRC_INTERVAL = 3;
    localparam int SRC_ALARM = 4;
    localparam int SRC_PS0 = 5;
    localparam int SRC_PS1 = 6;
    // ========================================
    // event carrier, one same-clock pulse per source
    typedef struct packed {
        logic second_prescaler_flag;
        logic first_prescaler_flag;
        logic alarm_flag;
        logic interval_event_flag;
        logic ready_flag;
        logic tamper_event_flag;
        logic osc_fail_flag;
    } rvc_evt_s;
endpackage : rvc_pkg
`default_nettype wire

/* File: sim/rvc_vector_convert_regs_monitor.sv */
`default_nettype none
module rvc_monitor
    import rvc_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // write side
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic [1:0] S_AXI_BRESP_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // read side
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    // ========================================
    // decode of the request taken at this edge
    wire logic ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire logic wr_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    wire logic [7:0] ra = S_AXI_ARADDR_I;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ========================================
    // assertions
    a_read_answer: assert property (ar_take |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read answer not one cycle after address");
    a_read_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read data dropped before accepted");
    a_write_answer: assert property (wr_take |=> S_AXI_BVALID_O && !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write answer not one cycle after both halves");
    a_bresp_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write response dropped before accepted");
    a_count_narrow: assert property (ar_take && (ra == OFS_PS0 || ra == OFS_PS1) |=> S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("prescale count wider than eight bits");
    a_vector_code: assert property (ar_take && ra == OFS_IV |=> S_AXI_RDATA_O[31:5] == 27'h0 && !S_AXI_RDATA_O[0] && S_AXI_RDATA_O[4:0] <= 5'h10)
        else $error("vector outside the code set");
    a_bcd_width: assert property (ar_take && ra == OFS_B2D |=> S_AXI_RDATA_O[31:16] == 16'h0)
        else $error("decimal result wider than four digits");
    a_bin_width: assert property (ar_take && ra == OFS_D2B |=> S_AXI_RDATA_O[31:12] == 20'h0)
        else $error("binary result wider than twelve bits");
    a_secs_top_zero: assert property (ar_take && ra == OFS_SEC |=> S_AXI_RDATA_O[31:6] == 26'h0)
        else $error("seconds backup upper bits set");
    a_mapped_okay: assert property (ar_take && ra <= OFS_EN && ra[1:0] == 2'b00 |=> S_AXI_RRESP_O == RESP_OKAY)
        else $error("mapped read refused");
    c_vector_hit: cover property (ar_take && ra == OFS_IV ##1 S_AXI_RDATA_O != 32'h0);
    c_slverr: cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == RESP_SLVERR);
    c_write: cover property (wr_take);
endmodule // rvc_monitor

bind rvc_vector_convert_regs rvc_monitor u_mon (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
    .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I));
`default_nettype wire

/* File: sim/test_rtc_vector_convert_regs.sv */
`default_nettype none
module test_rtc_vector_convert_regs;
    import rvc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam bit TP = 1'b1;
    logic clk = 0, rst_n = 0, sup_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, tick = 0;
    logic awr, wr, bv, arr, rv, wake;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd, d;
    logic [1:0] bresp, rresp, resp;
    // second copy built without tamper detection, fed the same bus, so both vector encodings run
    logic wake0;
    logic [31:0] rd0, d0;
    logic [1:0] rresp0;
    rvc_evt_s evt = '0;
    int err_count = 0, tests_run = 0, n;
    always #12.5 clk = ~clk;
    rvc_vector_convert_regs #(.TAMPER_PRESENT(TP)) dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .RTC_SUPPLY_RST_N_I(sup_n),
        .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rd), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rr), .EVENTS_I(evt), .PS0_TICK_I(tick), .WAKE_O(wake));
    rvc_vector_convert_regs #(.TAMPER_PRESENT(1'b0)) dut_plain (.SYS_CLK_I(clk), .RST_N_I(rst_n),
        .RTC_SUPPLY_RST_N_I(sup_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(), .S_AXI_BRESP_O(),
        .S_AXI_BVALID_O(), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(), .S_AXI_RDATA_O(rd0), .S_AXI_RRESP_O(rresp0), .S_AXI_RVALID_O(),
        .S_AXI_RREADY_I(rr), .EVENTS_I(evt), .PS0_TICK_I(tick), .WAKE_O(wake0));
    // ========================================
    // closing report
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timed_out(input int cnt);
        if (cnt >= 50) begin
            err_count++;
            results();
        end
    endtask
    // ========================================
    // bus tasks: entered just after an edge, leave one idle edge behind
    task automatic wr32(input logic [7:0] a, input logic [31:0] v);
        awa <= a; wd <= v; awv <= 1; wv <= 1; br <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
            if (bv) break;
        end
        br <= 0;
        timed_out(n);
        chk("write response", {30'h0, RESP_OKAY}, {30'h0, bresp});
        @(posedge clk);
    endtask
    task automatic rd32(input logic [7:0] a);
        ara <= a; arv <= 1; rr <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arv && arr) arv <= 0;
            if (rv) break;
        end
        d = rd; resp = rresp; d0 = rd0; rr <= 0;
        timed_out(n);
        @(posedge clk);
    endtask
    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd32(a);
        chk(what, exp, d);
        chk("read response", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask
    task automatic pulse(input rvc_evt_s v);
        evt <= v;
        @(posedge clk);
        evt <= '0;
        @(posedge clk);
    endtask
    function automatic logic [15:0] to_bcd(input int v);
        return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
    endfunction
    // ========================================
    // scenarios
    logic [15:0] bcds [4] = '{16'h0000, 16'h0059, 16'h0999, 16'h4095};
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        sup_n <= 1;
        @(posedge clk);
        rchk("vector after reset", OFS_IV, 32'h0);
        rchk("bin to bcd after reset", OFS_B2D, 32'h0);
        wr32(OFS_PS0, 32'h0000_00ff);
        wr32(OFS_PS1, 32'h0000_005a);
        rchk("stage0 count", OFS_PS0, 32'hff);
        tick <= 1;
        @(posedge clk);
        tick <= 0;
        @(posedge clk);
        rchk("stage0 wrapped", OFS_PS0, 32'h00);
        rchk("stage1 carried", OFS_PS1, 32'h5b);
        for (int i = 0; i < 4; i++) begin
            wr32(OFS_B2D, 32'(i * 1365));
            rchk("bin to bcd", OFS_B2D, {16'h0, to_bcd(i * 1365)});
            wr32(OFS_D2B, {16'h0, bcds[i]});
            rchk("bcd to bin", OFS_D2B, {16'h0, 4'h0, 12'(bcds[i][15:12] * 1000 + bcds[i][11:8] * 100 + bcds[i][7:4] * 10 + bcds[i][3:0])});
        end
        pulse(7'h7f);
        rchk("vector while masked", OFS_IV, 32'h0);
        chk("wake while masked", 32'h0, {31'h0, wake});
        wr32(OFS_EN, 32'h7f);
        wr32(OFS_IV, 32'hffff);
        chk("wake when enabled", 32'h1, {31'h0, wake});
        for (int i = 0; i < NUM_SRC; i++) begin
            if (TP || i != SRC_TAMPER) begin
                rchk("vector order", OFS_IV, 32'((TP || i == 0) ? 2 * (i + 1) : 2 * i));
                chk("plain vector order", 32'((i < NUM_SRC - 1) ? 2 * (i + 1) : 0), d0);
            end
        end
        rchk("vector drained", OFS_IV, 32'h0);
        chk("plain vector drained", 32'h0, d0);
        chk("wake after clear", 32'h0, {31'h0, wake});
        chk("plain wake after clear", 32'h0, {31'h0, wake0});
        rd32(8'h40);
        chk("unmapped response", {30'h0, RESP_SLVERR}, {30'h0, resp});
        wr32(OFS_SEC, 32'h0000_00ff);
        rchk("seconds masked", OFS_SEC, 32'h3f);
        rst_n <= 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rchk("seconds kept over core reset", OFS_SEC, 32'h3f);
        sup_n <= 0;
        repeat (3) @(posedge clk);
        sup_n <= 1;
        @(posedge clk);
        rchk("seconds after supply reset", OFS_SEC, 32'h0);
        results();
    end
endmodule // test_rtc_vector_convert_regs
`default_nettype wire
